/* File: pmcr_host_model.sv */
`timescale 1ns/1ps
module pmcr_host_model (
  input wire logic i_core_clk, // core clock
  output logic [7:0] o_cmd, // command code
  output logic o_wr, // write pulse
  output logic [3:0] o_wr_len, // write length
  output logic [95:0] o_wr_data, // write data
  output logic o_rd // read pulse
);
  initial begin
    o_cmd = 8'h00;
    o_wr = 1'b0;
    o_wr_len = 4'h0;
    o_wr_data = '0;
    o_rd = 1'b0;
  end
  // ==========================================================
  // one request after an idle gap, held for one edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [3:0] n, input logic [95:0] d, input int gap);
    repeat (gap) @(posedge i_core_clk);
    @(posedge i_core_clk);
    o_cmd <= c;
    o_wr_len <= n; // length as passed in n, 12 bytes for a block
    o_wr_data <= d;
    o_wr <= w;
    o_rd <= !w;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_wr_data <= ~d; // released data shows no stale value
    @(negedge i_core_clk);
  endtask
endmodule // pmcr_host_model

/* File: pmcr_pin_sync.sv */
`timescale 1ns/1ps
module pmcr_pin_sync #(
  parameter int W = 3
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_n, // synchronised reset, active low
  input wire logic i_ce, // clock enable
  input wire logic [W-1:0] i_async, // raw pin levels
  output logic [W-1:0] o_level // filtered levels
);
  // ==========================================================
  // parameter check
  if (W < 1) begin : g_width_check
    $error("pin sync needs at least one pin");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } pmcr_sync_t;

  pmcr_sync_t st_reg;
  pmcr_sync_t st_next;

  // ==========================================================
  // three stages; a change counts once stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_async;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.level[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.level;
endmodule // pmcr_pin_sync

/* File: pmcr_pkg.sv */
// Functional notes
// - gain calibration writes for vout, vin and iout are taken only within 0x1999..0x2666, and both voltage gains reset to 0x2000.
// - offset calibration writes are taken only with exponent -12 for vout, -3 for vin and -4 for iout.
// - voltage calibration factors are pushed to nonvolatile storage, and every calibration write is refused while write protect is on.
// - bit 1 of the low byte of the module type register is the write protect enable, 1 active and 0 inactive.
// - the firmware revision is a read-only byte whose upper nibble is the major and lower nibble the minor revision.
// - with the alert bit set the module answers only the alert response address while alert is asserted, else it keeps its programmed address.
// - pin assignment code 0000 gives secondary on/off and power ok, 0001 trim and power ok, 0010 trim and secondary on/off.
// - with the combination bit clear the secondary on/off pin is ignored, with it set the output needs both primary and secondary enables;
// the code needs only the primary enable with pin code 0001, which maps no secondary pin.
// - on/off logic bit 0 sets secondary polarity, 0 active low and 1 active high, and both on/off logic bits reset to 0.
// - power ok polarity bit 0 drives the pin low when asserted if 0 and high when asserted if 1, resetting to 1.
// - the date, location and serial register moves as a 12-byte block, and block writes are refused under write protect.
// - the six-bit module name identifies the variant, its top bit 1 for isolated units and 0 for non-isolated ones.
package pmcr_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_MODULE_TYPE = 8'hd0;
  localparam logic [7:0] CMD_VOUT_GAIN = 8'hd1;
  localparam logic [7:0] CMD_VOUT_OFFSET = 8'hd2;
  localparam logic [7:0] CMD_VIN_GAIN = 8'hd3;
  localparam logic [7:0] CMD_VIN_OFFSET = 8'hd4;
  localparam logic [7:0] CMD_IOUT_GAIN = 8'hd6;
  localparam logic [7:0] CMD_IOUT_OFFSET = 8'hd7;
  localparam logic [7:0] CMD_FW_REV = 8'hdb;
  localparam logic [7:0] CMD_ALERT_PIN = 8'he0;
  localparam logic [7:0] CMD_ONOFF_LOGIC = 8'he1;
  localparam logic [7:0] CMD_POK_POLARITY = 8'he2;
  localparam logic [7:0] CMD_DATE_LOC_SN = 8'hf0;
  // ==========================================================
  // transfer lengths in bytes
  localparam logic [3:0] LEN_BYTE = 4'h1;
  localparam logic [3:0] LEN_WORD = 4'h2;
  localparam logic [3:0] LEN_BLOCK = 4'hc;
  // ==========================================================
  // field positions
  localparam int WRITE_PROTECT_ENABLE_BIT = 1;
  localparam int NAME_LSB = 2;
  localparam int ARA_BIT = 4;
  localparam int COMB_BIT = 1;
  localparam int SEC_POL_BIT = 0;
  localparam int POK_POL_BIT = 0;
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  // ==========================================================
  // limits, codes and reset values
  localparam logic [15:0] GAIN_MIN = 16'h1999;
  localparam logic [15:0] GAIN_MAX = 16'h2666;
  localparam logic [15:0] GAIN_DEFAULT = 16'h2000;
  localparam logic [4:0] EXP_VOUT_OFFSET = 5'h14;
  localparam logic [4:0] EXP_VIN_OFFSET = 5'h1d;
  localparam logic [4:0] EXP_IOUT_OFFSET = 5'h1c;
  localparam logic [3:0] PIN_SEC_POK = 4'h0;
  localparam logic [3:0] PIN_TRIM_POK = 4'h1;
  localparam logic [3:0] PIN_TRIM_SEC = 4'h2;
  localparam logic WRITE_PROTECT_ENABLE_DEFAULT = 1'b1;
  localparam logic POK_POL_DEFAULT = 1'b1;

  function automatic logic pmcr_gain_ok(input logic [15:0] v);
    return (v >= GAIN_MIN) && (v <= GAIN_MAX);
  endfunction

  function automatic logic pmcr_exp_ok(input logic [15:0] v, input logic [4:0] e);
    return v[EXP_MSB:EXP_LSB] == e;
  endfunction
endpackage

/* File: pmcr_regs.sv */
`timescale 1ns/1ps
module pmcr_regs
  import pmcr_pkg::*;
#(
  parameter logic [7:0] P_FW_REV = 8'h11, // arbitrary value
  parameter logic P_ISOLATED = 1'b1, // isolated unit
  parameter logic [4:0] P_VARIANT = 5'h15 // arbitrary value
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_ce, // clock enable
  input wire logic [7:0] i_cmd, // command code
  input wire logic i_wr, // write request pulse
  input wire logic [3:0] i_wr_len, // write byte count
  input wire logic [95:0] i_wr_data, // write data, byte 0 low
  input wire logic i_rd, // read request pulse
  output logic [95:0] o_rd_data, // read data, byte 0 low
  output logic [3:0] o_rd_len, // read byte count
  output logic o_rd_valid, // read answer pulse
  output logic o_wr_ack, // write taken pulse
  output logic o_wr_nack, // write refused pulse
  output logic o_cmd_err, // unknown command pulse
  output logic o_nv_wr, // flash store pulse
  output logic [7:0] o_nv_cmd, // flash store command
  output logic [15:0] o_nv_data, // flash store data
  input wire logic i_alert_active, // alert line asserted
  output logic o_ara_only, // answer alert response address only
  input wire logic i_primary_enable, // primary on/off enable pin
  input wire logic i_trim_config_pin_one, // multi-function pin one
  input wire logic i_config_pin_two, // multi-function pin two input
  output logic o_config_pin_two, // multi-function pin two output
  output logic o_config_pin_two_oe, // pin two output enable
  output logic o_trim_sel, // pin one used as trim
  input wire logic i_power_ok, // internal power ok
  output logic o_output_enable, // regulator enable
  output logic [15:0] o_vout_gain, // vout gain factor
  output logic [15:0] o_vout_offset, // vout offset
  output logic [15:0] o_vin_gain, // vin gain factor
  output logic [15:0] o_vin_offset, // vin offset
  output logic [15:0] o_iout_gain, // iout gain factor
  output logic [15:0] o_iout_offset // iout offset
);
  typedef struct packed {
    logic [15:0] vout_gain;
    logic [15:0] vout_off;
    logic [15:0] vin_gain;
    logic [15:0] vin_off;
    logic [15:0] iout_gain;
    logic [15:0] iout_off;
    logic write_protect_enable;
    logic ara;
    logic [3:0] pincfg;
    logic comb;
    logic sec_pol;
    logic pok_pol;
    logic [95:0] mdls;
    logic [95:0] rd_data;
    logic [3:0] rd_len;
    logic rd_valid;
    logic wr_ack;
    logic wr_nack;
    logic cmd_err;
    logic nv_wr;
    logic [7:0] nv_cmd;
    logic [15:0] nv_data;
    logic out_en;
    logic pin2_o;
    logic pin2_oe;
    logic ara_only;
  } pmcr_state_t;

  localparam pmcr_state_t ST_RESET = '{
    vout_gain: GAIN_DEFAULT,
    vin_gain: GAIN_DEFAULT,
    iout_gain: GAIN_DEFAULT,
    vout_off: {EXP_VOUT_OFFSET, 11'h000},
    vin_off: {EXP_VIN_OFFSET, 11'h000},
    iout_off: {EXP_IOUT_OFFSET, 11'h000},
    write_protect_enable: WRITE_PROTECT_ENABLE_DEFAULT,
    pok_pol: POK_POL_DEFAULT,
    default: '0
  };

  logic rst_s1_reg;
  logic rst_n_reg;
  logic [2:0] pins;
  pmcr_state_t st_reg;
  pmcr_state_t st_next;

  // ==========================================================
  // reset release
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  pmcr_pin_sync #(.W(3)) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n_reg),
    .i_ce(i_ce),
    .i_async({i_primary_enable, i_trim_config_pin_one, i_config_pin_two}),
    .o_level(pins)
  );

  // ==========================================================
  // register writes, reads and pin logic
  always_comb begin
    logic [15:0] w16;
    logic ok;
    logic known;
    logic sec_mapped;
    logic sec_raw;
    logic sec_en;
    logic pok_mapped;
    logic locked;
    w16 = i_wr_data[15:0];
    ok = 1'b0;
    known = 1'b1;
    sec_mapped = 1'b0;
    sec_raw = 1'b0;
    sec_en = 1'b0;
    pok_mapped = 1'b0;
    locked = st_reg.write_protect_enable;
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.wr_ack = 1'b0;
    st_next.wr_nack = 1'b0;
    st_next.cmd_err = 1'b0;
    st_next.nv_wr = 1'b0;
    if (i_wr) begin
      st_next.nv_cmd = i_cmd;
      st_next.nv_data = w16;
      case (i_cmd)
        CMD_MODULE_TYPE: begin
          ok = (i_wr_len == LEN_WORD);
          if (ok) begin
            st_next.write_protect_enable = w16[WRITE_PROTECT_ENABLE_BIT];
          end
        end
        CMD_VOUT_GAIN: begin
          ok = !locked && (i_wr_len == LEN_WORD) && pmcr_gain_ok(w16);
          if (ok) begin
            st_next.vout_gain = w16;
            st_next.nv_wr = 1'b1;
          end
        end
        CMD_VOUT_OFFSET: begin
          ok = !locked && (i_wr_len == LEN_WORD) && pmcr_exp_ok(w16, EXP_VOUT_OFFSET);
          if (ok) begin
            st_next.vout_off = w16;
            st_next.nv_wr = 1'b1;
          end
        end
        CMD_VIN_GAIN: begin
          ok = !locked && (i_wr_len == LEN_WORD) && pmcr_gain_ok(w16);
          if (ok) begin
            st_next.vin_gain = w16;
            st_next.nv_wr = 1'b1;
          end
        end
        CMD_VIN_OFFSET: begin
          ok = !locked && (i_wr_len == LEN_WORD) && pmcr_exp_ok(w16, EXP_VIN_OFFSET);
          if (ok) begin
            st_next.vin_off = w16;
            st_next.nv_wr = 1'b1;
          end
        end
        CMD_IOUT_GAIN: begin
          ok = !locked && (i_wr_len == LEN_WORD) && pmcr_gain_ok(w16);
          if (ok) begin
            st_next.iout_gain = w16;
          end
        end
        CMD_IOUT_OFFSET: begin
          ok = !locked && (i_wr_len == LEN_WORD) && pmcr_exp_ok(w16, EXP_IOUT_OFFSET);
          if (ok) begin
            st_next.iout_off = w16;
          end
        end
        CMD_FW_REV: begin
          ok = 1'b0;
        end
        CMD_ALERT_PIN: begin
          ok = (i_wr_len == LEN_BYTE) && (w16[3:0] <= PIN_TRIM_SEC);
          if (ok) begin
            st_next.ara = w16[ARA_BIT];
            st_next.pincfg = w16[3:0];
          end
        end
        CMD_ONOFF_LOGIC: begin
          ok = (i_wr_len == LEN_BYTE);
          if (ok) begin
            st_next.comb = w16[COMB_BIT];
            st_next.sec_pol = w16[SEC_POL_BIT];
          end
        end
        CMD_POK_POLARITY: begin
          ok = (i_wr_len == LEN_BYTE);
          if (ok) begin
            st_next.pok_pol = w16[POK_POL_BIT];
          end
        end
        CMD_DATE_LOC_SN: begin
          ok = !locked && (i_wr_len == LEN_BLOCK);
          if (ok) begin
            st_next.mdls = i_wr_data;
          end
        end
        default: begin
          known = 1'b0;
        end
      endcase
      st_next.nv_wr = st_next.nv_wr & ok;
      st_next.wr_ack = ok;
      st_next.wr_nack = !ok;
      st_next.cmd_err = !known;
    end
    if (i_rd) begin
      st_next.rd_valid = 1'b1;
      st_next.rd_data = '0;
      st_next.rd_len = LEN_WORD;
      case (i_cmd)
        CMD_MODULE_TYPE: st_next.rd_data[7:0] = {P_ISOLATED, P_VARIANT, locked, 1'b0};
        CMD_VOUT_GAIN: st_next.rd_data[15:0] = st_reg.vout_gain;
        CMD_VOUT_OFFSET: st_next.rd_data[15:0] = st_reg.vout_off;
        CMD_VIN_GAIN: st_next.rd_data[15:0] = st_reg.vin_gain;
        CMD_VIN_OFFSET: st_next.rd_data[15:0] = st_reg.vin_off;
        CMD_IOUT_GAIN: st_next.rd_data[15:0] = st_reg.iout_gain;
        CMD_IOUT_OFFSET: st_next.rd_data[15:0] = st_reg.iout_off;
        CMD_FW_REV: begin
          st_next.rd_data[7:0] = P_FW_REV;
          st_next.rd_len = LEN_BYTE;
        end
        CMD_ALERT_PIN: begin
          st_next.rd_data[7:0] = {3'h0, st_reg.ara, st_reg.pincfg};
          st_next.rd_len = LEN_BYTE;
        end
        CMD_ONOFF_LOGIC: begin
          st_next.rd_data[7:0] = {6'h00, st_reg.comb, st_reg.sec_pol};
          st_next.rd_len = LEN_BYTE;
        end
        CMD_POK_POLARITY: begin
          st_next.rd_data[7:0] = {7'h00, st_reg.pok_pol};
          st_next.rd_len = LEN_BYTE;
        end
        CMD_DATE_LOC_SN: begin
          st_next.rd_data = st_reg.mdls;
          st_next.rd_len = LEN_BLOCK;
        end
        default: begin
          st_next.rd_len = '0;
          st_next.cmd_err = 1'b1;
        end
      endcase
    end
    // secondary on/off and power ok routing
    sec_mapped = (st_reg.pincfg == PIN_SEC_POK) || (st_reg.pincfg == PIN_TRIM_SEC);
    sec_raw = (st_reg.pincfg == PIN_SEC_POK) ? pins[1] : pins[0];
    sec_en = st_reg.sec_pol ? sec_raw : !sec_raw;
    st_next.out_en = pins[2] && (!st_reg.comb || !sec_mapped || sec_en);
    pok_mapped = (st_reg.pincfg == PIN_SEC_POK) || (st_reg.pincfg == PIN_TRIM_POK);
    st_next.pin2_oe = pok_mapped;
    st_next.pin2_o = pok_mapped && (st_reg.pok_pol ? i_power_ok : !i_power_ok);
    st_next.ara_only = st_reg.ara && i_alert_active;
  end

  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg <= ST_RESET;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_rd_data = st_reg.rd_data;
  assign o_rd_len = st_reg.rd_len;
  assign o_rd_valid = st_reg.rd_valid;
  assign o_wr_ack = st_reg.wr_ack;
  assign o_wr_nack = st_reg.wr_nack;
  assign o_cmd_err = st_reg.cmd_err;
  assign o_nv_wr = st_reg.nv_wr;
  assign o_nv_cmd = st_reg.nv_cmd;
  assign o_nv_data = st_reg.nv_data;
  assign o_ara_only = st_reg.ara_only;
  assign o_config_pin_two = st_reg.pin2_o;
  assign o_config_pin_two_oe = st_reg.pin2_oe;
  assign o_trim_sel = (st_reg.pincfg != PIN_SEC_POK);
  assign o_output_enable = st_reg.out_en;
  assign o_vout_gain = st_reg.vout_gain;
  assign o_vout_offset = st_reg.vout_off;
  assign o_vin_gain = st_reg.vin_gain;
  assign o_vin_offset = st_reg.vin_off;
  assign o_iout_gain = st_reg.iout_gain;
  assign o_iout_offset = st_reg.iout_off;

  // ==========================================================
  // assertions
  property p_gain_range;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && i_wr && (i_cmd == CMD_VOUT_GAIN) && !pmcr_gain_ok(i_wr_data[15:0]) |=> o_wr_nack && !o_wr_ack;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain out of range was taken");

  property p_offset_exp;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && i_wr && (i_cmd == CMD_VIN_OFFSET) && !pmcr_exp_ok(i_wr_data[15:0], EXP_VIN_OFFSET)
      |=> o_wr_nack && $stable(o_vin_offset);
  endproperty
  a_offset_exp: assert property (p_offset_exp) else $error("offset with wrong exponent was taken");

  property p_wp_lock;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && i_wr && st_reg.write_protect_enable && (i_cmd >= CMD_VOUT_GAIN) && (i_cmd <= CMD_IOUT_OFFSET)
      |=> o_wr_nack && !o_nv_wr;
  endproperty
  a_wp_lock: assert property (p_wp_lock) else $error("calibration write passed write protect");

  property p_wp_read;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && i_rd && (i_cmd == CMD_MODULE_TYPE)
      |=> o_rd_data[WRITE_PROTECT_ENABLE_BIT] == $past(st_reg.write_protect_enable);
  endproperty
  a_wp_read: assert property (p_wp_read) else $error("write protect bit misread");

  property p_fw_read;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && i_rd && (i_cmd == CMD_FW_REV) |=> o_rd_valid && (o_rd_data[7:0] == P_FW_REV) && (o_rd_len == LEN_BYTE);
  endproperty
  a_fw_read: assert property (p_fw_read) else $error("firmware revision misread");

  property p_ara;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && !st_reg.ara |=> !o_ara_only;
  endproperty
  a_ara: assert property (p_ara) else $error("alert response used while disabled");

  property p_pin_trim_sec;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && (st_reg.pincfg == PIN_TRIM_SEC) |=> !o_config_pin_two_oe;
  endproperty
  a_pin_trim_sec: assert property (p_pin_trim_sec) else $error("pin two driven while used as input");

  sequence s_comb_off;
    i_ce && !st_reg.comb;
  endsequence
  property p_comb_off;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      s_comb_off |=> (o_output_enable == $past(pins[2]));
  endproperty
  a_comb_off: assert property (p_comb_off) else $error("secondary input not ignored");

  property p_pok_pol;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && (st_reg.pincfg == PIN_TRIM_POK) |=> o_config_pin_two == ($past(st_reg.pok_pol) ~^ $past(i_power_ok));
  endproperty
  a_pok_pol: assert property (p_pok_pol) else $error("power ok pin polarity wrong");

  property p_block_len;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && i_wr && (i_cmd == CMD_DATE_LOC_SN) && (i_wr_len != LEN_BLOCK) |=> o_wr_nack;
  endproperty
  a_block_len: assert property (p_block_len) else $error("short block write was taken");

  property p_name_msb;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && i_rd && (i_cmd == CMD_MODULE_TYPE) |=> o_rd_data[7] == P_ISOLATED;
  endproperty
  a_name_msb: assert property (p_name_msb) else $error("module name top bit wrong");

  property p_reserved;
    @(posedge i_core_clk) disable iff (!rst_n_reg)
      i_ce && i_rd && (i_cmd == CMD_ONOFF_LOGIC) |=> o_rd_data[7:2] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
endmodule // pmcr_regs

/* File: tb_pmbus_mfr_config_regs.sv */
`timescale 1ns/1ps
module tb_pmbus_mfr_config_regs;
  import pmcr_pkg::*;
  localparam logic [7:0] FW = 8'h5a; // arbitrary value
  localparam logic [4:0] VAR = 5'h0b; // arbitrary value
  logic clk, rstn, ce, alert, pok, link_clk, prim, pin1, pin2_drv, w1, w2, wp, wp_on, sec;
  logic wr, rd, rv, ack, nack, cerr, nvwr, ara, p2o, p2oe, trim, oen;
  logic [7:0] cmd, nvcmd, c;
  logic [3:0] wlen, rlen, code;
  logic [95:0] wdata, rdata, r;
  logic [15:0] nvdata;
  logic [15:0] cal [6];
  logic [15:0] bnd [4] = '{16'h1998, 16'h1999, 16'h2666, 16'h2667};
  logic [95:0] mdl [256];
  logic [7:0] cmds [13] = '{CMD_MODULE_TYPE, CMD_VOUT_GAIN, CMD_VOUT_OFFSET, CMD_VIN_GAIN, CMD_VIN_OFFSET,
    CMD_IOUT_GAIN, CMD_IOUT_OFFSET, CMD_FW_REV, CMD_ALERT_PIN, CMD_ONOFF_LOGIC, CMD_POK_POLARITY, CMD_DATE_LOC_SN, 8'hd5};
  int n_errors = 0;
  int comparisons = 0;
  int seed = 94;
  wire logic pin2 = p2oe ? p2o : pin2_drv;

  pmcr_regs #(.P_FW_REV(FW), .P_ISOLATED(1'b1), .P_VARIANT(VAR)) dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_cmd(cmd), .i_wr(wr), .i_wr_len(wlen), .i_wr_data(wdata),
    .i_rd(rd), .o_rd_data(rdata), .o_rd_len(rlen), .o_rd_valid(rv), .o_wr_ack(ack), .o_wr_nack(nack),
    .o_cmd_err(cerr), .o_nv_wr(nvwr), .o_nv_cmd(nvcmd), .o_nv_data(nvdata), .i_alert_active(alert),
    .o_ara_only(ara), .i_primary_enable(prim), .i_trim_config_pin_one(pin1), .i_config_pin_two(pin2),
    .o_config_pin_two(p2o), .o_config_pin_two_oe(p2oe), .o_trim_sel(trim), .i_power_ok(pok),
    .o_output_enable(oen), .o_vout_gain(cal[0]), .o_vout_offset(cal[1]), .o_vin_gain(cal[2]),
    .o_vin_offset(cal[3]), .o_iout_gain(cal[4]), .o_iout_offset(cal[5]));
  pmcr_host_model host (.i_core_clk(clk), .o_cmd(cmd), .o_wr(wr), .o_wr_len(wlen), .o_wr_data(wdata), .o_rd(rd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // pins move on a slow clock unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    #37;
    forever #100 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    pin1 <= w1;
    pin2_drv <= w2;
    prim <= wp;
  end
  // ==========================================================
  // reference model
  function automatic logic [3:0] xlen(input logic [7:0] k);
    if (k == CMD_DATE_LOC_SN) return 4'hc;
    if (k >= CMD_MODULE_TYPE && k <= CMD_IOUT_OFFSET && k != 8'hd5) return 4'h2;
    if (k == CMD_FW_REV || (k >= CMD_ALERT_PIN && k <= CMD_POK_POLARITY)) return 4'h1;
    return 4'h0;
  endfunction
  function automatic logic [4:0] xexp(input logic [7:0] k);
    return (k == CMD_VOUT_OFFSET) ? 5'(-12) : (k == CMD_VIN_OFFSET) ? 5'(-3) : 5'(-4);
  endfunction
  function automatic logic accept(input logic [7:0] k, input logic [3:0] n, input logic [95:0] d);
    if (n != xlen(k) || n == 4'h0 || k == CMD_FW_REV) return 1'b0;
    if (k == CMD_VOUT_GAIN || k == CMD_VIN_GAIN || k == CMD_IOUT_GAIN) return !wp_on && d[15:0] >= 16'h1999 && d[15:0] <= 16'h2666;
    if (k == CMD_VOUT_OFFSET || k == CMD_VIN_OFFSET || k == CMD_IOUT_OFFSET) return !wp_on && d[15:11] == xexp(k);
    if (k == CMD_DATE_LOC_SN) return !wp_on;
    if (k == CMD_ALERT_PIN) return d[3:0] <= 4'h2;
    return 1'b1;
  endfunction
  function automatic logic [95:0] view(input logic [7:0] k);
    if (k == CMD_MODULE_TYPE) return {88'h0, 1'b1, VAR, wp_on, 1'b0};
    if (k == CMD_FW_REV) return {88'h0, FW};
    return mdl[k];
  endfunction
  task automatic chk_b(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_v(input string nm, input logic [95:0] e, input logic [95:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] k, input logic [3:0] n, input logic [95:0] d);
    logic a, nv;
    a = w && accept(k, n, d);
    nv = a && k >= CMD_VOUT_GAIN && k <= CMD_VIN_OFFSET;
    host.xfer(w, k, n, d, {$random(seed)} % 3);
    if (w) begin
      chk_b("wr_ack", a, ack);
      chk_b("wr_nack", !a, nack);
      chk_b("nv_wr", nv, nvwr);
      if (nv) chk_v("nv_store", {k, d[15:0]}, {nvcmd, nvdata});
      if (a) begin
        case (k)
          CMD_MODULE_TYPE: wp_on = d[1];
          CMD_ALERT_PIN: mdl[k] = {91'h0, d[4:0]};
          CMD_ONOFF_LOGIC: mdl[k] = {94'h0, d[1:0]};
          CMD_POK_POLARITY: mdl[k] = {95'h0, d[0]};
          CMD_DATE_LOC_SN: mdl[k] = d;
          default: mdl[k] = {80'h0, d[15:0]};
        endcase
      end
    end else begin
      chk_b("rd_valid", 1'b1, rv);
      chk_v("rd_len", xlen(k), rlen);
      chk_v("rd_data", view(k), rdata);
    end
    chk_b("cmd_err", xlen(k) == 4'h0, cerr);
    chk_v("cal_out", {mdl[cmds[1]][15:0], mdl[cmds[2]][15:0], mdl[cmds[3]][15:0], mdl[cmds[4]][15:0],
      mdl[cmds[5]][15:0], mdl[cmds[6]][15:0]}, {cal[0], cal[1], cal[2], cal[3], cal[4], cal[5]});
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    summarize();
  end
  // ==========================================================
  // tests
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    {alert, pok, w1, w2, wp, pin1, pin2_drv, prim} = '0;
    wp_on = 1'b1;
    for (int i = 0; i < 256; i++) mdl[i] = '0;
    for (int i = 1; i < 7; i++) mdl[cmds[i]] = (i % 2) ? 96'(16'h2000) : 96'({xexp(cmds[i]), 11'h000});
    mdl[CMD_POK_POLARITY] = 96'h1;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 11; i++) op(1'b0, cmds[i], 4'h0, '0);
    op(1'b1, CMD_DATE_LOC_SN, 4'hc, '1);
    op(1'b1, CMD_MODULE_TYPE, 4'h2, '0);
    op(1'b1, CMD_DATE_LOC_SN, 4'hc, {$random(seed), $random(seed), $random(seed)});
    op(1'b1, CMD_DATE_LOC_SN, 4'h2, '0);
    op(1'b0, CMD_DATE_LOC_SN, 4'h0, '0);
    $display("test reset_block done");
    for (int i = 1; i < 7; i++) begin
      for (int k = 0; k < 4; k++) op(1'b1, cmds[i], 4'h2, (i % 2) ? 96'(bnd[k]) : 96'({xexp(cmds[i]) + 5'(k), 11'h2a5}));
      op(1'b0, cmds[i], 4'h0, '0);
    end
    $display("test limits done");
    @(posedge clk);
    ce <= 1'b0;
    host.xfer(1'b1, CMD_POK_POLARITY, 4'h1, '0, 0);
    chk_b("frozen_ack", 1'b0, ack);
    @(posedge clk);
    ce <= 1'b1;
    op(1'b0, CMD_POK_POLARITY, 4'h0, '0);
    $display("test clock_enable done");
    for (int k = 0; k < 24; k++) begin
      r = {$random(seed), $random(seed), $random(seed)};
      op(1'b1, CMD_ALERT_PIN, 4'h1, {91'h0, r[4], 2'b00, 2'(k % 3)});
      op(1'b1, CMD_ONOFF_LOGIC, 4'h1, 96'(8'hf0 + k / 3));
      op(1'b1, CMD_POK_POLARITY, 4'h1, 96'(8'hfe + k / 12));
      op(1'b0, CMD_ONOFF_LOGIC, 4'h0, '0);
      code = mdl[CMD_ALERT_PIN][3:0];
      repeat (2) begin
        @(posedge clk);
        {w1, w2, wp, pok, alert} <= r[9:5];
        r = r >> 5;
        repeat (24) @(posedge clk);
        @(negedge clk);
        sec = (code == 4'h0) ? w1 : w2;
        chk_b("out_en", wp && (!mdl[CMD_ONOFF_LOGIC][1] || code == 4'h1 || sec == mdl[CMD_ONOFF_LOGIC][0]), oen);
        chk_b("trim_sel", code != 4'h0, trim);
        chk_b("pin2_oe", code != 4'h2, p2oe);
        if (code != 4'h2) chk_b("pin2", pok == mdl[CMD_POK_POLARITY][0], p2o);
        chk_b("ara_only", mdl[CMD_ALERT_PIN][4] && alert, ara);
      end
    end
    $display("test pins done");
    for (int j = 0; j < 300; j++) begin
      c = cmds[{$random(seed)} % 13];
      r = {$random(seed), $random(seed), $random(seed)};
      if (r[40]) r[15:0] = r[44] ? {xexp(c), r[10:0]} : 16'h1999 + 16'(r[63:52]);
      op(r[92], c, (r[95:93] == 3'h0) ? r[91:88] : xlen(c), r);
    end
    $display("test random done");
    summarize();
  end
endmodule // tb_pmbus_mfr_config_regs
